/* File: pkg/ccu_pkg.sv */
// Constants shared by the dual-array capture/compare unit.
// Assumes a single 100 MHz clock and a word-indexed register port.
package ccu_pkg;

	// Sizes
	localparam int NCH      = 32;         // Two arrays of sixteen channels
	localparam int ARR_SIZE = 16;
	localparam int NTMR     = 4;          // Two time bases of two timers each
	localparam int TW       = 16;
	localparam int AW       = 8;
	localparam int DW       = 32;
	localparam int DBL_OFS  = 8;          // Upper half of an array pairs with lower half

	// Register indices (word index on the register port)
	localparam logic [7:0] OFS_VAL   = 8'h00;  // 0x00..0x1f channel values
	localparam logic [7:0] OFS_CFG   = 8'h20;  // 0x20..0x3f channel configuration
	localparam logic [7:0] OFS_TMR   = 8'h40;  // 0x40..0x43 timer counts
	localparam logic [7:0] OFS_REL   = 8'h44;  // 0x44..0x47 reload values
	localparam logic [7:0] OFS_TCTL  = 8'h48;  // 0x48..0x4b timer control
	localparam logic [7:0] OFS_STAT  = 8'h50;  // Channel request flags, write 1 clears
	localparam logic [7:0] OFS_TSTAT = 8'h51;  // Timer request flags, write 1 clears
	localparam logic [7:0] OFS_MASK  = 8'h52;  // Channel request enables
	localparam logic [7:0] OFS_TMASK = 8'h53;  // Timer request enables

	// Channel configuration fields, layout is implementation defined
	localparam int CFG_W    = 5;          // RULE_19
	localparam int CFG_TSEL = 3;          // 0 primary, 1 secondary timer
	localparam int CFG_DBL  = 4;          // Double register mode, upper-half channel
	localparam logic [2:0] M_OFF   = 3'h0;
	localparam logic [2:0] M_CAP_R = 3'h1;
	localparam logic [2:0] M_CAP_F = 3'h2;
	localparam logic [2:0] M_CAP_B = 3'h3;
	localparam logic [2:0] M_CMP0  = 3'h4;
	localparam logic [2:0] M_CMP1  = 3'h5;
	localparam logic [2:0] M_CMP2  = 3'h6;
	localparam logic [2:0] M_CMP3  = 3'h7;

	// Timer control fields
	localparam int TCTL_W   = 4;
	localparam int TCTL_RUN = 3;
	localparam logic [2:0] CK_DIV8  = 3'h0;  // Divide by 8, 16, 32, 64 for codes 0..3
	localparam logic [2:0] CK_GPT   = 3'h4;
	localparam logic [2:0] CK_EXT   = 3'h5;  // Primary timers only

	// Channels with no output driver
	localparam int IN_ONLY_LO = 24;
	localparam int IN_ONLY_HI = 27;

	// Finest timer step: 400 ns at a 20 MHz system clock
	localparam int FINE_RES_NS = 400;
	localparam int REF_SYS_MHZ = 20;
	localparam int PRESC_MIN   = FINE_RES_NS * REF_SYS_MHZ / 1000;  // 8 clocks
	localparam int PRESC_W     = 6;

	localparam logic [TW-1:0] TMR_MAX = 16'hffff;
	localparam logic [TW-1:0] RST_16  = 16'h0000;

endpackage

/* File: rtl/ccu_top.sv */
// Dual time-base capture/compare unit: four timers, two 16-channel arrays.
// Assumes one ref_clk domain; pins and external count inputs are asynchronous,
// the general timer overflow pulse comes from logic on ref_clk.
//
// Behaviour
// RULE_01: Four 16-bit reloadable timers, two pairs forming two time bases.
// RULE_02: Timer clock from prescaled system clock or general timer overflow.
// RULE_03: Primary timers may count rising edges on an external count input.
// RULE_04: Two arrays of sixteen capture/compare channels, thirty-two in all.
// RULE_05: Each channel selects timer of its array and capture or compare.
// RULE_06: One pin per channel; channels 24 to 27 never drive their pin.
// RULE_07: Capture latches assigned timer value on the selected pin event.
// RULE_08: Every capture sets the channel request flag.
// RULE_09: Capture edge selectable: rising, falling or both.
// RULE_10: Compare channels match continuously; action depends on mode.
// RULE_11: Mode 0 raises requests only, any number per period.
// RULE_12: Mode 1 toggles the pin on every match.
// RULE_13: Mode 2 raises requests only, at most one per period.
// RULE_14: Mode 3 sets pin on match, clears on overflow, once per period.
// RULE_15: Double mode: two channels toggle one shared pin on either match.
// RULE_16: Fastest prescaler steps timers once every eight system clocks.
// RULE_17: Each channel and timer has request and enable flags.
// RULE_18: Overflow reloads the timer and defines the timer period.
// RULE_19: Prescaler codes, mode codes and register layout are implementation choices.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module ccu_top
	import ccu_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                reset,
	// Register port
	input  wire logic [AW-1:0]       reg_addr,
	input  wire logic [DW-1:0]       reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [DW-1:0]       reg_rdata,
	// Timing sources
	input  wire logic                gpt_ovf_pulse,
	input  wire logic [1:0]          ext_count_pin,
	// Channel pins
	input  wire logic [NCH-1:0]      cc_pin_in,
	output logic      [NCH-1:0]      cc_pin_out,
	output logic      [NCH-1:0]      cc_pin_oe,
	// Interrupt
	output logic                     irq
);

	////////////////////////////////////////////////////////////////////////
	// Storage
	logic [TW-1:0]     val_reg  [NCH];
	logic [CFG_W-1:0]  cfg_reg  [NCH];
	logic [TW-1:0]     tmr_reg  [NTMR];
	logic [TW-1:0]     rel_reg  [NTMR];
	logic [TCTL_W-1:0] tctl_reg [NTMR];
	logic [NCH-1:0]    stat_reg, mask_reg, once_reg, pin_reg, oe_reg;
	logic [NTMR-1:0]   tstat_reg, tmask_reg, ovf_reg, upd_reg;
	logic [PRESC_W-1:0] presc_reg;
	logic [NCH-1:0]    sync1_reg, sync2_reg, prev_reg;
	logic [1:0]        ext1_reg, ext2_reg, extp_reg;
	logic [DW-1:0]     rdata_reg;
	logic              irq_reg;
	logic [NTMR-1:0]   tick;
	logic [NCH-1:0]    cap_ev, cmp_hit, cmp_ev, tog;

	// Timer index of a channel: array bit above the select bit
	function automatic logic [1:0] tmr_of(input int c, input logic [CFG_W-1:0] cfg);
		tmr_of = {(c >= ARR_SIZE) ? 1'b1 : 1'b0, cfg[CFG_TSEL]};
	endfunction

	function automatic logic is_cmp(input logic [CFG_W-1:0] cfg);
		is_cmp = cfg[2];
	endfunction

	// True for an upper-half compare channel in double mode, false for any lower-half channel
	function automatic logic dbl_up(input int c, input logic [CFG_W-1:0] cfg);
		dbl_up = cfg[CFG_DBL] && is_cmp(cfg) && ((c % ARR_SIZE) >= DBL_OFS);
	endfunction

	// Prescaler tap: divide by 8 << code
	function automatic logic presc_hit(input logic [1:0] code,
		input logic [PRESC_W-1:0] cnt);
		logic [PRESC_W-1:0] msk;
		msk = PRESC_W'((PRESC_MIN << code) - 1);
		presc_hit = ((cnt & msk) == msk);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers; only stage two and its delayed copy feed any logic
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
			ext1_reg  <= 2'h0;
			ext2_reg  <= 2'h0;
			extp_reg  <= 2'h0;
		end else begin
			sync1_reg <= cc_pin_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			ext1_reg  <= ext_count_pin;
			ext2_reg  <= ext1_reg;
			extp_reg  <= ext2_reg;
		end
	end

	// Free-running prescaler
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			presc_reg <= '0;
		else
			presc_reg <= presc_reg + 1'b1;  // RULE_16
	end

	////////////////////////////////////////////////////////////////////////
	// Count enables per timer
	always_comb begin
		for (int t = 0; t < NTMR; t++) begin
			logic [2:0] sel;
			sel = tctl_reg[t][2:0];
			if (sel <= 3'h3)
				tick[t] = presc_hit(sel[1:0], presc_reg);  // RULE_02 RULE_16
			else if (sel == CK_GPT)
				tick[t] = gpt_ovf_pulse;  // RULE_02
			else if (sel == CK_EXT && t % 2 == 0)
				tick[t] = ext2_reg[t/2] & ~extp_reg[t/2];  // RULE_03
			else
				tick[t] = 1'b0;
			tick[t] = tick[t] & tctl_reg[t][TCTL_RUN];
		end
	end

	// Timers count up and reload on overflow; a software write takes priority
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int t = 0; t < NTMR; t++)
				tmr_reg[t] <= RST_16;
			ovf_reg <= '0;
			upd_reg <= '0;
		end else begin
			for (int t = 0; t < NTMR; t++) begin
				ovf_reg[t] <= 1'b0;
				upd_reg[t] <= 1'b0;
				if (reg_wr && reg_addr == OFS_TMR + 8'(t)) begin
					tmr_reg[t] <= reg_wdata[TW-1:0];
				end else if (tick[t]) begin
					upd_reg[t] <= 1'b1;
					if (tmr_reg[t] == TMR_MAX) begin
						tmr_reg[t] <= rel_reg[t];  // RULE_18 RULE_01
						ovf_reg[t] <= 1'b1;
					end else begin
						tmr_reg[t] <= tmr_reg[t] + 1'b1;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel event detection
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			logic [1:0] t;
			logic       rise, fall;
			t    = tmr_of(c, cfg_reg[c]);
			rise = sync2_reg[c] & ~prev_reg[c];
			fall = ~sync2_reg[c] & prev_reg[c];
			unique case (cfg_reg[c][2:0])  // RULE_09 RULE_19
				M_CAP_R: cap_ev[c] = rise;
				M_CAP_F: cap_ev[c] = fall;
				M_CAP_B: cap_ev[c] = rise | fall;
				default: cap_ev[c] = 1'b0;
			endcase
			// Match only on the cycle after the timer steps, so one count value
			// gives one event however long the timer rests on it
			cmp_hit[c] = is_cmp(cfg_reg[c]) && upd_reg[t]
				&& tmr_reg[t] == val_reg[c];  // RULE_10
			if (cfg_reg[c][2:0] == M_CMP2 || cfg_reg[c][2:0] == M_CMP3)
				cmp_ev[c] = cmp_hit[c] & ~once_reg[c];  // RULE_13 RULE_14
			else
				cmp_ev[c] = cmp_hit[c];  // RULE_11
		end
	end

	// Pin toggles: own mode 1 match, plus match of an upper double partner
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			tog[c] = (cfg_reg[c][2:0] == M_CMP1) && !dbl_up(c, cfg_reg[c])
				&& cmp_ev[c];  // RULE_12
			// Modulo keeps the partner index in range on lanes that never pair
			if ((c % ARR_SIZE) < DBL_OFS
				&& dbl_up(c + DBL_OFS, cfg_reg[(c + DBL_OFS) % NCH]))
				tog[c] = tog[c] ^ cmp_ev[(c + DBL_OFS) % NCH];  // RULE_15
		end
	end

	// One-per-period latch, released by the assigned timer's overflow
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			once_reg <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (cmp_ev[c])
					once_reg[c] <= 1'b1;
				else if (ovf_reg[tmr_of(c, cfg_reg[c])])
					once_reg[c] <= 1'b0;  // RULE_18
			end
		end
	end

	// Output pins and their drivers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_reg <= '0;
			oe_reg  <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				logic drv;
				drv = (cfg_reg[c][2:0] == M_CMP1 || cfg_reg[c][2:0] == M_CMP3)
					&& !dbl_up(c, cfg_reg[c]);
				if ((c % ARR_SIZE) < DBL_OFS)
					drv = drv | dbl_up(c + DBL_OFS, cfg_reg[(c + DBL_OFS) % NCH]);
				// Input-only channels never drive, whatever the mode
				oe_reg[c] <= drv && !(c >= IN_ONLY_LO && c <= IN_ONLY_HI);  // RULE_06
				if (cfg_reg[c][2:0] == M_CMP3) begin
					// Match wins over an overflow in the same cycle
					if (cmp_ev[c])
						pin_reg[c] <= 1'b1;  // RULE_14
					else if (ovf_reg[tmr_of(c, cfg_reg[c])])
						pin_reg[c] <= 1'b0;  // RULE_14
				end else if (tog[c]) begin
					pin_reg[c] <= ~pin_reg[c];  // RULE_12 RULE_15
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel values: capture beats a software write in the same cycle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int c = 0; c < NCH; c++)
				val_reg[c] <= RST_16;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (cap_ev[c])
					val_reg[c] <= tmr_reg[tmr_of(c, cfg_reg[c])];  // RULE_07
				else if (reg_wr && reg_addr == OFS_VAL + 8'(c))
					val_reg[c] <= reg_wdata[TW-1:0];
			end
		end
	end

	// Configuration, reload and timer control registers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int c = 0; c < NCH; c++)
				cfg_reg[c] <= '0;
			for (int t = 0; t < NTMR; t++) begin
				rel_reg[t]  <= RST_16;
				tctl_reg[t] <= '0;
			end
			mask_reg  <= '0;
			tmask_reg <= '0;
		end else if (reg_wr) begin
			for (int c = 0; c < NCH; c++)
				if (reg_addr == OFS_CFG + 8'(c))
					cfg_reg[c] <= reg_wdata[CFG_W-1:0];  // RULE_05 RULE_04
			for (int t = 0; t < NTMR; t++) begin
				if (reg_addr == OFS_REL + 8'(t))
					rel_reg[t] <= reg_wdata[TW-1:0];
				if (reg_addr == OFS_TCTL + 8'(t))
					tctl_reg[t] <= reg_wdata[TCTL_W-1:0];
			end
			if (reg_addr == OFS_MASK)
				mask_reg <= reg_wdata;  // RULE_17
			if (reg_addr == OFS_TMASK)
				tmask_reg <= reg_wdata[NTMR-1:0];
		end
	end

	// Request flags: write one to clear, a new event in the same cycle wins
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			stat_reg  <= '0;
			tstat_reg <= '0;
		end else begin
			logic [NCH-1:0]  clr;
			logic [NTMR-1:0] tclr;
			clr  = (reg_wr && reg_addr == OFS_STAT) ? reg_wdata : '0;
			tclr = (reg_wr && reg_addr == OFS_TSTAT) ? reg_wdata[NTMR-1:0] : '0;
			stat_reg  <= (stat_reg & ~clr) | cap_ev | cmp_ev;  // RULE_08 RULE_17
			tstat_reg <= (tstat_reg & ~tclr) | ovf_reg;  // RULE_17
		end
	end

	// Interrupt level
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(stat_reg & mask_reg) || |(tstat_reg & tmask_reg);
	end

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= '0;
			if (reg_rd) begin
				if (reg_addr < OFS_CFG)
					rdata_reg <= DW'(val_reg[reg_addr[4:0]]);
				else if (reg_addr < OFS_TMR)
					rdata_reg <= DW'(cfg_reg[reg_addr[4:0]]);
				else if (reg_addr < OFS_REL)
					rdata_reg <= DW'(tmr_reg[reg_addr[1:0]]);
				else if (reg_addr < OFS_TCTL)
					rdata_reg <= DW'(rel_reg[reg_addr[1:0]]);
				else if (reg_addr < OFS_TCTL + 8'h4)
					rdata_reg <= DW'(tctl_reg[reg_addr[1:0]]);
				else if (reg_addr == OFS_STAT)
					rdata_reg <= stat_reg;
				else if (reg_addr == OFS_TSTAT)
					rdata_reg <= DW'(tstat_reg);
				else if (reg_addr == OFS_MASK)
					rdata_reg <= mask_reg;
				else if (reg_addr == OFS_TMASK)
					rdata_reg <= DW'(tmask_reg);
			end
		end
	end

	assign reg_rdata  = rdata_reg;
	assign cc_pin_out = pin_reg;
	assign cc_pin_oe  = oe_reg;
	assign irq        = irq_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	logic p8;
	assign p8 = presc_hit(2'h0, presc_reg);

	sequence s_gap8;
		!p8 [*7] ##1 p8;
	endsequence

	// Watched channels are the ones the bench drives, so no check stays idle
	sequence s_cap2;
		cap_ev[2] && !(reg_wr && reg_addr == OFS_VAL + 8'h02);
	endsequence

	chk_presc_rate: assert property (p8 |=> s_gap8)  // RULE_16
		else $error("prescaler step not every eight clocks");

	chk_capture_latch: assert property (s_cap2 |=>  // RULE_07
		val_reg[2] == $past(tmr_reg[tmr_of(2, cfg_reg[2])]))
		else $error("capture did not latch timer value");

	chk_capture_flag: assert property (cap_ev[2] |=> stat_reg[2])  // RULE_08
		else $error("capture did not set request flag");

	// Own match or double partner match toggles; both at once cancel
	chk_toggle_pin: assert property (cfg_reg[5][2:0] == M_CMP1  // RULE_12 RULE_15
		&& (cmp_ev[5] ^ (dbl_up(13, cfg_reg[13]) && cmp_ev[13]))
		|=> pin_reg[5] != $past(pin_reg[5]))
		else $error("mode 1 match did not toggle pin");

	chk_once_period: assert property (cfg_reg[6][2:0] == M_CMP2  // RULE_13
		&& once_reg[6] |-> !cmp_ev[6])
		else $error("second mode 2 event in one period");

	chk_mode3_clear: assert property (cfg_reg[8][2:0] == M_CMP3  // RULE_14
		&& !cmp_ev[8] && ovf_reg[tmr_of(8, cfg_reg[8])] |=> !pin_reg[8])
		else $error("mode 3 pin not cleared on overflow");

	chk_timer_reload: assert property (ovf_reg[1]  // RULE_18
		|-> tmr_reg[1] == $past(rel_reg[1]))
		else $error("overflow did not reload timer");

	chk_input_only: assert property (cc_pin_oe[IN_ONLY_HI:IN_ONLY_LO] == 4'h0)  // RULE_06
		else $error("input-only channel drives its pin");

	chk_irq_level: assert property (##1 irq  // RULE_17
		== $past(|(stat_reg & mask_reg) || |(tstat_reg & tmask_reg)))
		else $error("interrupt level does not follow flags");

endmodule

/* File: test/ccu_pin_world.sv */
// Far side of the capture/compare unit: channel pins, count inputs, overflow pulse.
// Assumes a rising-edge ref_clk; every change after time zero lands by non-blocking assignment.
`timescale 1ns/1ps
module ccu_pin_world (
	// Clock
	input  wire logic        ref_clk,
	// Pins toward the unit
	output logic      [31:0] cc_pin_in,
	output logic      [1:0]  ext_count_pin,
	output logic             gpt_ovf_pulse
);
	// Quiet pins at time zero
	initial begin
		cc_pin_in = 32'h0000_0000;
		ext_count_pin = 2'h0;
		gpt_ovf_pulse = 1'b0;
	end

	// Move one channel pin; the level holds until the next call
	task automatic set_pin(input int ch, input logic lvl);
		@(posedge ref_clk);
		cc_pin_in[ch] <= lvl;
	endtask

	// One-cycle overflow pulse, as the general timer gives it
	task automatic gpt_tick();
		@(posedge ref_clk);
		gpt_ovf_pulse <= 1'b1;
		@(posedge ref_clk);
		gpt_ovf_pulse <= 1'b0;
	endtask

	// Slow square wave so the synchroniser sees every level
	task automatic ext_edges(input int b, input int n);
		repeat (n) begin
			repeat (4) @(posedge ref_clk);
			ext_count_pin[b] <= 1'b1;
			repeat (4) @(posedge ref_clk);
			ext_count_pin[b] <= 1'b0;
		end
	endtask
endmodule

/* File: test/dual_array_capture_compare_bench.sv */
// Self-checking bench for the capture/compare unit with a behavioural compare model.
// Assumes ccu_pkg and the pin partner; timer 1 is stepped by overflow pulses.
`timescale 1ns/1ps
module dual_array_capture_compare_bench
	import ccu_pkg::*;
;
	logic                ref_clk;
	logic                reset;
	logic                reg_wr;
	logic                reg_rd;
	logic                gpt_ovf_pulse;
	logic                irq;
	logic                hit;
	logic                out5;
	logic                out8;
	logic     [AW-1:0]   reg_addr;
	logic     [DW-1:0]   reg_wdata;
	logic     [DW-1:0]   reg_rdata;
	logic     [DW-1:0]   rd;
	logic     [1:0]      ext_count_pin;
	logic     [NCH-1:0]  cc_pin_in;
	logic     [NCH-1:0]  cc_pin_out;
	logic     [NCH-1:0]  cc_pin_oe;
	logic     [15:0]     seed;
	int                  miscompares;
	int                  num_checks;
	int                  tmr;
	int                  flags;
	int                  tflags;
	int                  v;
	int                  op;
	int                  lo;
	bit                  armed[5];
	int                  chs[5] = '{5, 6, 7, 8, 13};
	logic     [2:0]      mds[5] = '{M_CMP1, M_CMP2, M_CMP0, M_CMP3, M_CMP1};

	ccu_top ccu_top_inst (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.gpt_ovf_pulse(gpt_ovf_pulse), .ext_count_pin(ext_count_pin),
		.cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .irq(irq));
	ccu_pin_world ccu_pin_world_inst (.ref_clk(ref_clk), .cc_pin_in(cc_pin_in),
		.ext_count_pin(ext_count_pin), .gpt_ovf_pulse(gpt_ovf_pulse));

	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Register port: one-cycle strobes, read data in the following cycle only
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Model of one timer 1 step; reload is v - 1 so the next step meets v again
	task automatic model_step();
		if (tmr == 65535) begin
			tmr = v - 1;
			tflags |= 2;
			out8 = 1'b0;
			foreach (armed[i]) armed[i] = 1;
		end else
			tmr++;
		foreach (chs[i]) begin
			if (tmr == (i == 4 ? v + 1 : v)) begin
				if (mds[i] == M_CMP2 || mds[i] == M_CMP3) begin
					if (armed[i]) begin
						flags |= 1 << chs[i];
						armed[i] = 0;
						if (i == 3) out8 = 1'b1;
					end
				end else begin
					flags |= 1 << chs[i];
					if (i != 2) out5 = ~out5;
				end
			end
		end
	endtask

	// Hang guard: a run that outlives the bound counts as a mismatch
	initial begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		miscompares = 0;
		num_checks = 0;
		seed = 16'h005c;
		flags = 0;
		tflags = 0;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		rdr(OFS_STAT);
		check("stat_rst", rd, 32'h0);
		rdr(8'h7f);
		check("unmapped", rd, 32'h0);
		check("oe_rst", cc_pin_oe, 32'h0);
		check("out_rst", cc_pin_out, 32'h0);
		check("irq_rst", irq, 1'b0);
		// Capture from a stopped timer so the latched value is known
		seed = lfsr(seed);
		wr(OFS_TMR, {16'h0000, seed});
		for (int m = 1; m <= 3; m++) begin
			wr(OFS_CFG + 8'h02, m);
			wr(OFS_MASK, m == 3 ? 4 : 0);
			for (int e = 1; e >= 0; e--) begin
				ccu_pin_world_inst.set_pin(2, e[0]);
				repeat (6) @(posedge ref_clk);
				hit = (m == 3) || (m == 1 && e == 1) || (m == 2 && e == 0);
				rdr(OFS_STAT);
				check("cap_flag", rd[2], hit);
				check("cap_irq", irq, hit && m == 3);
				rdr(OFS_VAL + 8'h02);
				check("cap_val", rd, {16'h0000, seed});
				wr(OFS_STAT, 32'h0000_0004);
			end
		end
		repeat (2) @(posedge ref_clk);
		check("irq_clr", irq, 1'b0);
		// External count input on timer 0
		wr(OFS_TMR, 32'h0);
		wr(OFS_TCTL, {28'h0, 1'b1, CK_EXT});
		ccu_pin_world_inst.ext_edges(0, 3);
		repeat (6) @(posedge ref_clk);
		rdr(OFS_TMR);
		check("ext_cnt", rd, 32'h3);
		wr(OFS_TCTL, 32'h0);
		// Every prescaler code: 65 tick chances, phase unknown, so one step of slack
		for (int k = 0; k < 4; k++) begin
			wr(OFS_TMR + 8'h02, 32'h0);
			wr(OFS_TCTL + 8'h02, {28'h0, 1'b1, CK_DIV8 + 3'(k)});
			repeat (64) @(posedge ref_clk);
			rdr(OFS_TMR + 8'h02);
			lo = 65 >> (3 + k);
			check("div", rd >= lo && rd <= lo + 1, 32'h1);
			wr(OFS_TCTL + 8'h02, 32'h0);
		end
		// Compare channels on timer 1, stepped by overflow pulses
		seed = lfsr(seed);
		v = {17'h0, seed[14:1], 1'b1};
		foreach (chs[i]) begin
			wr(OFS_VAL + 8'(chs[i]), i == 4 ? v + 1 : v);
			wr(OFS_CFG + 8'(chs[i]), {27'h0, i == 4, 1'b1, mds[i]});
			armed[i] = 1;
		end
		wr(OFS_CFG + 8'd25, {29'h0, M_CMP3});
		wr(OFS_REL + 8'h01, v - 1);
		wr(OFS_TCTL + 8'h01, {28'h0, 1'b1, CK_GPT});
		out5 = 1'b0;
		out8 = 1'b0;
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			op = i < 4 ? i : int'(seed % 4);
			tmr = op == 0 ? v - 1 : op == 1 ? v : op == 2 ? 65535 : tmr;
			if (op != 3) wr(OFS_TMR + 8'h01, tmr);
			ccu_pin_world_inst.gpt_tick();
			model_step();
			repeat (6) @(posedge ref_clk);
			rdr(OFS_STAT);
			check("cmp_flags", rd, flags);
			check("pin5", cc_pin_out[5], out5);
			check("pin8", cc_pin_out[8], out8);
			check("oe", cc_pin_oe, 32'h0000_0120);
			rdr(OFS_TMR + 8'h01);
			check("tmr1", rd, tmr);
			rdr(OFS_TSTAT);
			check("tflag1", rd[1], tflags[1]);
			wr(OFS_STAT, 32'hffff_ffff);
			wr(OFS_TSTAT, 32'h0000_000f);
			flags = 0;
			tflags = 0;
		end
		end_of_test();
	end
endmodule
